// [verilog/ppq_pkg.sv]
// Shared constants and types for the port policing and queue map registers.
// Assumes a 12-bit byte address inside one port's register page.
package ppq_pkg;

	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 32;
	localparam int NUM_PRIO  = 8;
	localparam int MAP_FLD_W = 4;
	localparam int QSEL_W    = 2;
	localparam int PIDX_LSB  = 16;
	localparam int PIDX_W    = 3;
	localparam int QPTR_LSB  = 0;
	localparam int QPTR_W    = 2;
	localparam int PERF_LSB  = 8;
	localparam int PERF_W    = 2;
	localparam int CNTD_BIT  = 11;
	localparam int CTL_W     = 12;

	localparam logic [ADDR_W-1:0] OFF_PTR   = 12'h804;
	localparam logic [ADDR_W-1:0] OFF_MAP   = 12'h808;
	localparam logic [ADDR_W-1:0] OFF_CTL   = 12'h80c;
	localparam logic [ADDR_W-1:0] OFF_RATE  = 12'h820;
	localparam logic [ADDR_W-1:0] OFF_BURST = 12'h824;

	localparam logic [DATA_W-1:0] MAP_RST   = 32'h3322_1100;
	localparam logic [CTL_W-1:0]  CTL_RST   = 12'h020;
	localparam logic [DATA_W-1:0] RATE_RST  = 32'h1000_2000;
	localparam logic [DATA_W-1:0] BURST_RST = 32'h1000_3000;

	typedef enum logic [1:0] {
		PERF_DROPPED = 2'h0,
		PERF_GREEN   = 2'h1,
		PERF_YELLOW  = 2'h2,
		PERF_RED     = 2'h3
	} ppq_perf_t;

	// Field order follows the control word, bit 11 first
	typedef struct packed {
		logic      cnt_drop_only;
		logic      pm_drop_all;
		ppq_perf_t perf_sel;
		logic      per_port;
		logic [1:0] non_ip_frame_color;
		logic      mark_en;
		logic      remap_en;
		logic      srp_drop;
		logic      color_blind;
		logic      police_en;
	} ppq_ctl_t;

	typedef struct packed {
		logic       police_on;
		logic       wred_on;
		logic       color_blind;
		logic       color_aware;
		logic       remap_on;
		logic       mark_on;
		logic       srp_drop_ok;
		logic [1:0] non_ip_frame_color;
		logic       per_port;
		ppq_perf_t  perf_sel;
		logic       pm_drop_all;
		logic       cnt_drop_only;
	} ppq_pol_t;

endpackage

// [verilog/ppq_entry_mem.sv]
// Per port and queue entry store for one 32-bit rate or burst word.
// Assumes one write port; unwritten entries read as the reset word.
`timescale 1ns/1ps
module ppq_entry_mem #(
	parameter int          AW      = 5,
	parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
	input  wire logic          sys_clk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [31:0]   wr_data,
	input  wire logic [AW-1:0] cur_addr_nxt,
	output logic      [31:0]   cur_q,
	input  wire logic          mtr_en,
	input  wire logic [AW-1:0] mtr_addr,
	output logic      [31:0]   mtr_q
);
	localparam int DEPTH = 1 << AW;

	if (AW < 1 || AW > 16)
		$error("AW must lie between 1 and 16");

	logic [31:0]      mem [DEPTH];
	logic [DEPTH-1:0] vld_r;

	// Array has no reset; a valid bit per entry stands in for it
	always_ff @(posedge sys_clk) begin
		if (ce && wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			vld_r <= '0;
		else if (ce && wr_en)
			vld_r[wr_addr] <= 1'b1;
	end

	// Forwarding keeps the selected entry current after a same-cycle write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			cur_q <= RST_VAL;
		else if (ce) begin
			if (wr_en && wr_addr == cur_addr_nxt)
				cur_q <= wr_data;
			else if (vld_r[cur_addr_nxt])
				cur_q <= mem[cur_addr_nxt];
			else
				cur_q <= RST_VAL;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			mtr_q <= RST_VAL;
		else if (ce && mtr_en)
			mtr_q <= vld_r[mtr_addr] ? mem[mtr_addr] : RST_VAL;
	end
endmodule

// [verilog/ppq_regs.sv]
// Port ingress policing, WRED control and priority-to-queue map registers.
// Assumes a single-cycle strobe register port and a meter datapath outside.
//
// Summary of operation
// R1: Eight 4-bit map fields, priority p at bits 4p+3:4p, low two bits pick the queue.
// R2: After reset priorities 0-1 go to queue 0, 2-3 to 1, 4-5 to 2, 6-7 to 3.
// R3: Control bit 0 enables policing and WRED together and resets to zero.
// R4: Control bit 1 set gives color-blind metering, clear gives color-aware.
// R5: Control bit 2 set lets WRED drop stream-reservation packets, else never.
// R6: Control bit 3 set remaps the DSCP color in color-aware mode, else DSCP color is used.
// R7: Control bit 4 set marks the meter color into DSCP, else no marking.
// R8: Bits 6:5 give the color of non-IP frames in color-aware mode, reset 01.
// R9: Control bit 7 set polices per port and queue, clear uses port index zero entries.
// R10: Bits 9:8 pick which counter is read: 11 red, 10 yellow, 01 green, 00 dropped.
// R11: Control bit 10 set drops all while the memory maximum is exceeded, else probabilistic.
// R12: Control bit 11 set makes color counters count only dropped packets of that color.
// R13: Rate word holds committed rate 31:16 (0x1000) and peak rate 15:0 (0x2000).
// R14: Burst word holds committed burst 31:16 (0x1000) and peak burst 15:0 (0x3000).
// R15: Pointer word holds port index 18:16 and queue pointer 1:0 selecting the entry.
// R16: Reserved upper map bits never change which queue a frame enters.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module ppq_regs
	import ppq_pkg::*;
#(
	parameter int PORT_W  = 3,
	parameter int QUEUE_W = 2
) (
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic [DATA_W-1:0]  reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [DATA_W-1:0]  reg_rdata_r,
	input  wire logic               frm_valid,
	input  wire logic [2:0]         frm_prio,
	output logic                    frm_queue_vld_r,
	output logic      [QSEL_W-1:0]  frm_queue_r,
	input  wire logic               mtr_req,
	input  wire logic [PORT_W-1:0]  mtr_port,
	input  wire logic [QUEUE_W-1:0] mtr_queue,
	output logic                    mtr_vld_r,
	output logic      [DATA_W-1:0]  mtr_rate_r,
	output logic      [DATA_W-1:0]  mtr_burst_r,
	output ppq_pol_t                pol_r
);
	localparam int AW = PORT_W + QUEUE_W;

	if (PORT_W < 1 || PORT_W > PIDX_W)
		$error("PORT_W must lie between 1 and the pointer field width");
	if (QUEUE_W != QPTR_W || QUEUE_W != QSEL_W)
		$error("QUEUE_W must match the queue pointer width");

	logic [DATA_W-1:0]  map_r;
	ppq_ctl_t           ctl_r;
	logic [PORT_W-1:0]  pidx_r;
	logic [PORT_W-1:0]  pidx_nxt;
	logic [QUEUE_W-1:0] qptr_r;
	logic [QUEUE_W-1:0] qptr_nxt;
	logic [AW-1:0]      ent_addr;
	logic [AW-1:0]      cur_addr_nxt;
	logic [AW-1:0]      mtr_addr;
	logic [DATA_W-1:0]  rate_cur;
	logic [DATA_W-1:0]  burst_cur;
	logic [DATA_W-1:0]  ptr_word;
	logic               wr_ptr;
	logic               wr_map;
	logic               wr_ctl;
	logic               wr_rate;
	logic               wr_burst;

	assign wr_ptr   = reg_wr && reg_addr == OFF_PTR;
	assign wr_map   = reg_wr && reg_addr == OFF_MAP;
	assign wr_ctl   = reg_wr && reg_addr == OFF_CTL;
	assign wr_rate  = reg_wr && reg_addr == OFF_RATE;
	assign wr_burst = reg_wr && reg_addr == OFF_BURST;

	// R15: pointer fields
	always_comb begin
		pidx_nxt = pidx_r;
		qptr_nxt = qptr_r;
		if (wr_ptr) begin
			pidx_nxt = reg_wdata[PIDX_LSB +: PORT_W];
			qptr_nxt = reg_wdata[QPTR_LSB +: QUEUE_W];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pidx_r <= '0;
			qptr_r <= '0;
		end else if (ce) begin
			pidx_r <= pidx_nxt;
			qptr_r <= qptr_nxt;
		end
	end

	always_comb begin
		ptr_word = '0;
		ptr_word[PIDX_LSB +: PORT_W] = pidx_r;
		ptr_word[QPTR_LSB +: QUEUE_W] = qptr_r;
	end

	assign ent_addr     = {pidx_r, qptr_r};
	assign cur_addr_nxt = {pidx_nxt, qptr_nxt};

	// R9: aggregate limits come from port index zero
	assign mtr_addr = {ctl_r.per_port ? mtr_port : {PORT_W{1'b0}}, mtr_queue};

	// R1: map storage keeps all bits so reserved ones read back as written
	// R2: reset map spreads priority pairs over the four queues
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			map_r <= MAP_RST;
		else if (ce && wr_map)
			map_r <= reg_wdata;
	end

	// R3: control word, enable clear at reset
	// R8: non-IP color resets to 01
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ctl_r <= ppq_ctl_t'(CTL_RST);
		else if (ce && wr_ctl)
			ctl_r <= ppq_ctl_t'(reg_wdata[CTL_W-1:0]);
	end

	// R13: committed and peak rate per entry
	ppq_entry_mem #(
		.AW      (AW),
		.RST_VAL (RATE_RST)
	) u_rate (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.ce           (ce),
		.wr_en        (wr_rate),
		.wr_addr      (ent_addr),
		.wr_data      (reg_wdata),
		.cur_addr_nxt (cur_addr_nxt),
		.cur_q        (rate_cur),
		.mtr_en       (mtr_req),
		.mtr_addr     (mtr_addr),
		.mtr_q        (mtr_rate_r)
	);

	// R14: committed and peak burst per entry
	ppq_entry_mem #(
		.AW      (AW),
		.RST_VAL (BURST_RST)
	) u_burst (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.ce           (ce),
		.wr_en        (wr_burst),
		.wr_addr      (ent_addr),
		.wr_data      (reg_wdata),
		.cur_addr_nxt (cur_addr_nxt),
		.cur_q        (burst_cur),
		.mtr_en       (mtr_req),
		.mtr_addr     (mtr_addr),
		.mtr_q        (mtr_burst_r)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			mtr_vld_r <= 1'b0;
		else if (ce)
			mtr_vld_r <= mtr_req;
	end

	// Read data stand for one cycle only; unmapped offsets read zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata_r <= '0;
		else if (ce) begin
			reg_rdata_r <= '0;
			if (reg_rd) begin
				case (reg_addr)
					OFF_PTR:   reg_rdata_r <= ptr_word;
					OFF_MAP:   reg_rdata_r <= map_r;
					OFF_CTL:   reg_rdata_r <= DATA_W'(ctl_r);
					OFF_RATE:  reg_rdata_r <= rate_cur;
					OFF_BURST: reg_rdata_r <= burst_cur;
					default:   reg_rdata_r <= '0;
				endcase
			end
		end
	end

	// R16: only the low bits of a field reach the queue select
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			frm_queue_vld_r <= 1'b0;
			frm_queue_r     <= '0;
		end else if (ce) begin
			frm_queue_vld_r <= frm_valid;
			if (frm_valid)
				frm_queue_r <= map_r[MAP_FLD_W*frm_prio +: QSEL_W];
		end
	end

	// Gated view for the datapath; costs one cycle after a control write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			pol_r <= '0;
		else if (ce) begin
			// R3: one bit gates both policing and WRED
			pol_r.police_on <= ctl_r.police_en;
			pol_r.wred_on   <= ctl_r.police_en;
			// R4: blind or aware metering
			pol_r.color_blind <= ctl_r.police_en & ctl_r.color_blind;
			pol_r.color_aware <= ctl_r.police_en & ~ctl_r.color_blind;
			// R6: remap only matters in aware mode
			pol_r.remap_on <= ctl_r.police_en & ~ctl_r.color_blind
				& ctl_r.remap_en;
			// R7: DSCP color marking
			pol_r.mark_on <= ctl_r.police_en & ctl_r.mark_en;
			// R5: reservation streams protected unless allowed
			pol_r.srp_drop_ok <= ctl_r.police_en & ctl_r.srp_drop;
			// R8: color assumed for non-IP frames
			pol_r.non_ip_frame_color <= ctl_r.non_ip_frame_color;
			// R9: per port or aggregate policing
			pol_r.per_port <= ctl_r.per_port;
			// R10: counter selection for reads
			pol_r.perf_sel <= ctl_r.perf_sel;
			// R11: hard drop above the memory maximum
			pol_r.pm_drop_all <= ctl_r.police_en & ctl_r.pm_drop_all;
			// R12: color counters count drops only
			pol_r.cnt_drop_only <= ctl_r.cnt_drop_only;
		end
	end

	logic               seen_r;
	logic [QSEL_W-1:0]  frm_expect;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			seen_r <= 1'b0;
		else if (ce)
			seen_r <= 1'b1;
	end

	assign frm_expect = map_r[MAP_FLD_W*frm_prio +: QSEL_W];

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_reset_values: assert property ( // R2
		!seen_r |-> map_r == MAP_RST && ctl_r == ppq_ctl_t'(CTL_RST)
	) else $error("reset values wrong");

	a_map_lookup: assert property ( // R1
		ce && frm_valid |=> frm_queue_vld_r
			&& frm_queue_r == $past(frm_expect)
	) else $error("queue lookup wrong");

	a_reserved_ignored: assert property ( // R16
		ce && frm_valid && frm_prio == 3'h0 && map_r[1:0] == 2'h0
			|=> frm_queue_r == 2'h0
	) else $error("reserved map bits steer queue");

	a_police_gate: assert property ( // R3
		ce && !ctl_r.police_en |=> !pol_r.police_on && !pol_r.wred_on
			&& !pol_r.mark_on && !pol_r.pm_drop_all
	) else $error("policing active while disabled");

	a_color_mode: assert property ( // R4
		ce && ctl_r.police_en |=> pol_r.color_blind != pol_r.color_aware
			&& pol_r.color_blind == $past(ctl_r.color_blind)
	) else $error("police mode wrong");

	a_srp_protect: assert property ( // R5
		ce && !ctl_r.srp_drop |=> !pol_r.srp_drop_ok
	) else $error("reservation drop allowed");

	a_remap_aware: assert property ( // R6
		pol_r.remap_on |-> pol_r.color_aware
	) else $error("remap outside aware mode");

	a_mark_enable: assert property ( // R7
		ce && ctl_r.police_en && ctl_r.mark_en |=> pol_r.mark_on
	) else $error("marking not enabled");

	a_aggregate_port: assert property ( // R9
		!ctl_r.per_port |-> mtr_addr[AW-1 -: PORT_W] == '0
	) else $error("aggregate uses wrong port");

	a_perf_select: assert property ( // R10
		ce && wr_ctl ##1 ce |=> pol_r.perf_sel
			== ppq_perf_t'($past(reg_wdata[PERF_LSB +: PERF_W], 2))
	) else $error("counter select wrong");

	a_drop_count: assert property ( // R12
		ce && wr_ctl ##1 ce |=> pol_r.cnt_drop_only
			== $past(reg_wdata[CNTD_BIT], 2)
	) else $error("dropped color select wrong");

	a_rate_readback: assert property ( // R13
		ce && wr_rate ##1 ce && reg_rd && reg_addr == OFF_RATE
			|=> reg_rdata_r == $past(reg_wdata, 2)
	) else $error("rate readback wrong");

	a_burst_readback: assert property ( // R14
		ce && wr_burst ##1 ce && reg_rd && reg_addr == OFF_BURST
			|=> reg_rdata_r == $past(reg_wdata, 2)
	) else $error("burst readback wrong");

	a_ptr_update: assert property ( // R15
		ce && wr_ptr |=> qptr_r == $past(reg_wdata[QPTR_LSB +: QUEUE_W])
			&& pidx_r == $past(reg_wdata[PIDX_LSB +: PORT_W])
	) else $error("pointer not updated");

	a_read_oneshot: assert property (
		ce && !reg_rd |=> reg_rdata_r == '0
	) else $error("read data held too long");

	a_wred_gate: assert property ( // R3
		ce && ctl_r.police_en |=> pol_r.police_on && pol_r.wred_on
	) else $error("policing not enabled");

	a_map_write: assert property ( // R1
		ce && wr_map |=> map_r == $past(reg_wdata)
	) else $error("map write lost");

	a_non_ip_color: assert property ( // R8
		ce |=> pol_r.non_ip_frame_color == $past(ctl_r.non_ip_frame_color)
	) else $error("non-IP color wrong");

	a_per_port_view: assert property ( // R9
		ce |=> pol_r.per_port == $past(ctl_r.per_port)
	) else $error("policing scope wrong");

	a_pm_drop_all: assert property ( // R11
		ce |=> pol_r.pm_drop_all
			== $past(ctl_r.police_en && ctl_r.pm_drop_all)
	) else $error("hard drop select wrong");

	a_meter_valid: assert property ( // R13
		ce && mtr_req |=> mtr_vld_r
	) else $error("meter answer missing");

	a_ptr_readback: assert property ( // R15
		ce && reg_rd && reg_addr == OFF_PTR
			|=> reg_rdata_r == $past(ptr_word)
	) else $error("pointer readback wrong");

	// A low enable must hold the map, control and pointer registers, read data included
	a_ce_freeze: assert property (
		!ce |=> $stable(map_r) && $stable(ctl_r) && $stable(pidx_r)
			&& $stable(qptr_r) && $stable(reg_rdata_r)
	) else $error("state moved while frozen");

endmodule

// [sim/port_policing_queue_map_test.sv]
// Self-checking bench for the port policing and queue map registers.
// Assumes ppq_regs with default widths and a single 20 MHz clock.
`timescale 1ns/1ps
module port_policing_queue_map_test
	import ppq_pkg::*;
;
	logic                sys_clk;
	logic                rst_n;
	logic                ce;
	logic [ADDR_W-1:0]   reg_addr;
	logic [DATA_W-1:0]   reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [DATA_W-1:0]   reg_rdata_r;
	logic                frm_valid;
	logic [2:0]          frm_prio;
	logic                frm_queue_vld_r;
	logic [QSEL_W-1:0]   frm_queue_r;
	logic                mtr_req;
	logic [2:0]          mtr_port;
	logic [1:0]          mtr_queue;
	logic                mtr_vld_r;
	logic [DATA_W-1:0]   mtr_rate_r;
	logic [DATA_W-1:0]   mtr_burst_r;
	ppq_pol_t            pol_r;
	int                  mismatches;
	int                  tests_run;

	ppq_regs ppq_regs_i (
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.ce              (ce),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_wr          (reg_wr),
		.reg_rd          (reg_rd),
		.reg_rdata_r     (reg_rdata_r),
		.frm_valid       (frm_valid),
		.frm_prio        (frm_prio),
		.frm_queue_vld_r (frm_queue_vld_r),
		.frm_queue_r     (frm_queue_r),
		.mtr_req         (mtr_req),
		.mtr_port        (mtr_port),
		.mtr_queue       (mtr_queue),
		.mtr_vld_r       (mtr_vld_r),
		.mtr_rate_r      (mtr_rate_r),
		.mtr_burst_r     (mtr_burst_r),
		.pol_r           (pol_r)
	);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic give_verdict();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1 chk("read data", reg_rdata_r, exp);
	endtask

	task automatic look(input logic [2:0] p, input logic [1:0] q);
		@(posedge sys_clk);
		frm_valid <= 1'b1;
		frm_prio  <= p;
		@(posedge sys_clk);
		frm_valid <= 1'b0;
		#1 chk("queue valid", {31'h0, frm_queue_vld_r}, 32'h1);
		chk("queue", {30'h0, frm_queue_r}, {30'h0, q});
	endtask

	task automatic meter(input logic [2:0] p, input logic [1:0] q,
		input logic [31:0] rate, input logic [31:0] burst);
		@(posedge sys_clk);
		mtr_req   <= 1'b1;
		mtr_port  <= p;
		mtr_queue <= q;
		@(posedge sys_clk);
		mtr_req   <= 1'b0;
		#1 chk("meter valid", {31'h0, mtr_vld_r}, 32'h1);
		chk("meter rate", mtr_rate_r, rate);
		chk("meter burst", mtr_burst_r, burst);
	endtask

	// Gated control view as the meter side should see it
	function automatic logic [13:0] pol_exp(input logic [11:0] c);
		logic e;
		e = c[0];
		return {e, e, c[1] & e, ~c[1] & e, c[3] & ~c[1] & e, c[4] & e,
			c[2] & e, c[6:5], c[7], c[9:8], c[10] & e, c[11]};
	endfunction

	task automatic chk_pol(input logic [11:0] c);
		logic [13:0] pe;
		logic [13:0] p;
		pe = pol_exp(c);
		p  = pol_r;
		chk("pol gates", 32'(p[13:7]), 32'(pe[13:7]));
		chk("pol fields", 32'(p[6:0]), 32'(pe[6:0]));
	endtask

	// Write then read back with no idle cycle between the strobes
	task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
		reg_rd    <= 1'b1;
		@(posedge sys_clk);
		reg_rd    <= 1'b0;
		#1 chk("read after write", reg_rdata_r, d);
	endtask

	task automatic test_reset();
		rd(OFF_MAP, 32'h3322_1100);
		rd(OFF_CTL, 32'h0000_0020);
		rd(OFF_RATE, 32'h1000_2000);
		rd(OFF_BURST, 32'h1000_3000);
		rd(OFF_PTR, 32'h0);
		@(posedge sys_clk);
		#1 chk("read idle", reg_rdata_r, 32'h0);
		chk_pol(12'h020);
		for (int p = 0; p < 8; p++) begin
			look(3'(p), 2'(p / 2));
		end
	endtask

	task automatic test_map();
		logic [31:0] m;
		// Reserved bit 3 set in every field, low bits shuffled
		m = 32'hcdef_89ab;
		wr(OFF_MAP, m);
		rd(OFF_MAP, m);
		for (int p = 0; p < 8; p++) begin
			look(3'(p), m[4*p +: 2]);
		end
		wr(12'h810, 32'hffff_ffff);
		rd(12'h810, 32'h0);
		@(posedge sys_clk);
		ce <= 1'b0;
		wr(OFF_MAP, 32'h0);
		ce <= 1'b1;
		rd(OFF_MAP, m);
	endtask

	task automatic test_ctl();
		logic [11:0] tbl [8];
		tbl = '{12'hfff, 12'h001, 12'h00b, 12'h01e, 12'h100, 12'h200,
			12'h300, 12'hc85};
		foreach (tbl[i]) begin
			wr(OFF_CTL, {20'hfffff, tbl[i]});
			rd(OFF_CTL, {20'h0, tbl[i]});
			@(posedge sys_clk);
			#1 chk_pol(tbl[i]);
		end
	endtask

	task automatic test_entries();
		wr(OFF_CTL, 32'h0000_0001);
		wr(OFF_PTR, 32'hfffb_fffe);
		rd(OFF_PTR, 32'h0003_0002);
		wr(OFF_RATE, 32'habcd_1234);
		wr(OFF_BURST, 32'h5678_9abc);
		rd(OFF_RATE, 32'habcd_1234);
		rd(OFF_BURST, 32'h5678_9abc);
		meter(3'd3, 2'd2, 32'h1000_2000, 32'h1000_3000);
		wr(OFF_CTL, 32'h0000_0081);
		meter(3'd3, 2'd2, 32'habcd_1234, 32'h5678_9abc);
		meter(3'd3, 2'd1, 32'h1000_2000, 32'h1000_3000);
		meter(3'd0, 2'd2, 32'h1000_2000, 32'h1000_3000);
		wr(OFF_PTR, 32'h0000_0002);
		wr_rd(OFF_RATE, 32'h1111_2222);
		rd(OFF_BURST, 32'h1000_3000);
		wr_rd(OFF_BURST, 32'h4444_5555);
		wr(OFF_CTL, 32'h0000_0001);
		// Aggregate limit from port index zero, checked here with port 5
		meter(3'd5, 2'd2, 32'h1111_2222, 32'h4444_5555);
	endtask

	initial begin
		mismatches = 0;
		tests_run  = 0;
		rst_n      = 1'b0;
		ce         = 1'b1;
		reg_addr   = '0;
		reg_wdata  = '0;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		frm_valid  = 1'b0;
		frm_prio   = '0;
		mtr_req    = 1'b0;
		mtr_port   = '0;
		mtr_queue  = '0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		test_reset();
		test_map();
		test_ctl();
		test_entries();
		give_verdict();
	end

	// Whole run needs about 140 cycles; this is ample margin
	initial begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		give_verdict();
	end

endmodule
